// ===== standard_timer_module_regs_tb.sv
/*
 * Self-checking bench for tmr_core: registers over APB, counter, comparators and pin.
 * Assumes tmr_pkg and tmr_core are compiled first and pready answers without a fixed delay.
 */
`timescale 1ns/1ns
module standard_timer_module_regs_tb
	import tmr_pkg::*;
;
	// ************************************************************
	// Signals and tables
	// ************************************************************
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ext_clk;
	logic        sub_clk;
	logic        pin_in;
	logic        pin_out;
	logic        pin_oe;
	logic        ev_a;
	logic        ev_p;
	int          fails;
	int          compares;
	int          cyc;
	int          n_a;
	int          n_p;

	// Pin rows (five compare, then timer/counter and capture): control one, then pin after start, pin later, enable.
	localparam logic [7:0] PIN_C1 [7] = '{8'h19, 8'h29, 8'h21, 8'h1D, 8'h09, 8'hE9, 8'h70};
	localparam logic [2:0] PIN_EX [7] = '{3'h5, 3'h7, 3'h3, 3'h3, 3'h7, 3'h0, 3'h0};
	// Waveform rows: control one, compare A, window, cycles high.
	localparam logic [7:0] PWM_C1 [7] = '{8'hA8, 8'hA9, 8'hAA, 8'h88, 8'h98, 8'hA0, 8'hAC};
	localparam int         PWM_A  [7] = '{32, 32, 256, 32, 32, 32, 32};
	localparam int         PWM_W  [7] = '{128, 128, 256, 128, 128, 128, 128};
	localparam int         PWM_H  [7] = '{32, 32, 128, 0, 128, 96, 96};
	// Clock rows: control zero, stimulus kind, pulses or cycles, lowest and highest count.
	localparam logic [7:0] CK_C0  [7] = '{8'h68, 8'h78, 8'h48, 8'h58, 8'h08, 8'h28, 8'h38};
	localparam int         CK_K   [7] = '{1, 1, 2, 2, 0, 0, 0};
	localparam int         CK_N   [7] = '{5, 3, 4, 2, 40, 160, 640};
	// Internal rows run 13 cycles beyond their wait before the stop write lands.
	localparam int         CK_LO  [7] = '{5, 3, 4, 2, 13, 10, 10};
	localparam int         CK_HI  [7] = '{5, 3, 4, 2, 13, 11, 11};
	localparam int         CAP_N  [4] = '{1, 1, 2, 0};

	tmr_core dut_u (
		.pclk               (pclk),
		.presetn            (presetn),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.external_clock_pin (ext_clk),
		.sub_clock_in       (sub_clk),
		.timer_io_pin_in    (pin_in),
		.timer_io_pin_out   (pin_out),
		.timer_io_pin_oe    (pin_oe),
		.match_a_event      (ev_a),
		.match_p_event      (ev_p)
	);

	always #2 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc++;
		if (ev_a === 1'b1) n_a++;
		if (ev_p === 1'b1) n_p++;
		if (cyc == 40000) begin
			fails++;
			end_of_test();
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task end_of_test();
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task cw(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	task rd_cnt(output logic [9:0] v);
		logic [31:0] h;
		logic [31:0] l;
		rd(OFF_CNT_HI, h);
		rd(OFF_CNT_LO, l);
		v = {h[1:0], l[7:0]};
	endtask

	task set_cmp(input logic [9:0] v);
		wr(OFF_CMP_LO, {24'h0, v[7:0]});
		wr(OFF_CMP_HI, {30'h0, v[9:8]});
	endtask

	task stop();
		wr(OFF_CTRL0, 32'h10);
	endtask

	// Cycles between two successive events: 0 match P, 1 match A, 2 pin change.
	task gap(input int s, output int n);
		logic lp;
		logic hit;
		lp = pin_out;
		n = 0;
		for (int k = 0; k < 2200; k++) begin
			@(posedge pclk);
			hit = (s == 0) ? (ev_p === 1'b1) : (s == 1) ? (ev_a === 1'b1) : (pin_out !== lp);
			if (hit && n > 0) break;
			if (hit || n > 0) n++;
			lp = pin_out;
		end
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_reset();
		logic [31:0] r;
		logic        e;
		chk("pin_oe", 32'h1, {31'h0, pin_oe});
		chk("pin_out", 32'h0, {31'h0, pin_out});
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), r);
			chk("reg_reset", 32'h0, r);
		end
		wr(OFF_CNT_LO, 32'hFF);
		wr(OFF_CNT_HI, 32'hFF);
		rd(OFF_CNT_HI, r);
		chk("cnt_hi_ro", 32'h0, r);
		rd(OFF_CNT_LO, r);
		chk("cnt_lo_ro", 32'h0, r);
		apb(1'b0, 8'h18, 32'h0, r, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
		chk("unmapped_data", 32'h0, r);
		wr(OFF_CMP_HI, 32'hFFFFFFFF);
		rd(OFF_CMP_HI, r);
		chk("cmp_hi_unused", 32'h3, r);
		$display("t_reset done");
	endtask

	task t_pair();
		logic [31:0] r;
		set_cmp(10'h2A5);
		rd(OFF_CMP_HI, r);
		chk("cmp_hi", 32'h2, r);
		rd(OFF_CMP_LO, r);
		chk("cmp_lo", 32'hA5, r);
		wr(OFF_CMP_LO, 32'h11);
		rd(OFF_CMP_HI, r);
		rd(OFF_CMP_LO, r);
		chk("cmp_lo_uncommitted", 32'hA5, r);
		$display("t_pair done");
	endtask

	task t_onpause();
		logic [9:0] c1;
		logic [9:0] c2;
		stop();
		wr(OFF_CTRL1, 32'h0);
		wr(OFF_CTRL0, 32'h18);
		cw(40);
		wr(OFF_CTRL0, 32'h10);
		rd_cnt(c1);
		cw(20);
		rd_cnt(c2);
		chk("cnt_off_hold", {22'h0, c1}, {22'h0, c2});
		chk("cnt_ran", 32'h1, {31'h0, c1 > 10'h0});
		wr(OFF_CTRL0, 32'h98);
		rd_cnt(c1);
		chk("cnt_on_clear", 32'h0, {22'h0, c1});
		wr(OFF_CTRL0, 32'h18);
		cw(30);
		wr(OFF_CTRL0, 32'h98);
		rd_cnt(c1);
		cw(20);
		rd_cnt(c2);
		chk("cnt_pause_hold", {22'h0, c1}, {22'h0, c2});
		wr(OFF_CTRL0, 32'h18);
		rd_cnt(c2);
		chk("cnt_resume", 32'h1, {31'h0, c2 > c1});
		$display("t_onpause done");
	endtask

	task t_period();
		logic [2:0] code;
		int         n;
		wr(OFF_CTRL1, 32'h0);
		for (int i = 0; i < 3; i++) begin
			code = (i == 0) ? 3'h1 : (i == 1) ? 3'h7 : 3'h0;
			stop();
			wr(OFF_CTRL0, {24'h0, 5'h03, code});
			gap(0, n);
			chk("period_p", (code == 3'h0) ? 1024 : 128 * code, n);
		end
		stop();
		wr(OFF_CTRL1, 32'h01);
		set_cmp(10'd200);
		wr(OFF_CTRL0, 32'h19);
		gap(1, n);
		chk("period_a", 32'd200, n);
		n_p = 0;
		cw(400);
		chk("no_p_event", 32'h0, n_p);
		$display("t_period done");
	endtask

	task t_pin();
		int n;
		set_cmp(10'd16);
		for (int i = 0; i < 7; i++) begin
			stop();
			wr(OFF_CTRL1, {24'h0, PIN_C1[i]});
			wr(OFF_CTRL0, 32'h18);
			cw(3);
			chk("pin_oe_mode", {31'h0, PIN_EX[i][0]}, {31'h0, pin_oe});
			if (PIN_EX[i][0]) begin
				chk("pin_start", {31'h0, PIN_EX[i][2]}, {31'h0, pin_out});
				cw(60);
				chk("pin_late", {31'h0, PIN_EX[i][1]}, {31'h0, pin_out});
			end
		end
		stop();
		wr(OFF_CTRL1, 32'h31);
		wr(OFF_CTRL0, 32'h18);
		gap(2, n);
		chk("pin_toggle", 32'd16, n);
		$display("t_pin done");
	endtask

	task t_pwm();
		int h;
		for (int i = 0; i < 7; i++) begin
			stop();
			set_cmp(10'(PWM_A[i]));
			wr(OFF_CTRL1, {24'h0, PWM_C1[i]});
			wr(OFF_CTRL0, 32'h19);
			cw(300);
			h = 0;
			repeat (PWM_W[i]) begin
				@(posedge pclk);
				if (pin_out === 1'b1) h++;
			end
			chk("pwm_high", PWM_H[i], h);
		end
		$display("t_pwm done");
	endtask

	task t_single();
		logic [31:0] r;
		stop();
		set_cmp(10'd20);
		wr(OFF_CTRL1, 32'hB8);
		wr(OFF_CTRL0, 32'h19);
		cw(3);
		chk("pulse_lead", 32'h1, {31'h0, pin_out});
		cw(60);
		chk("pulse_trail", 32'h0, {31'h0, pin_out});
		rd(OFF_CTRL0, r);
		chk("pulse_on_cleared", 32'h11, r);
		$display("t_single done");
	endtask

	task t_clk();
		logic [9:0] c;
		wr(OFF_CTRL1, 32'h0);
		set_cmp(10'h0);
		for (int i = 0; i < 7; i++) begin
			stop();
			wr(OFF_CTRL0, {24'h0, CK_C0[i]});
			if (CK_K[i] == 0) cw(CK_N[i]);
			else repeat (CK_N[i]) begin
				if (CK_K[i] == 1) ext_clk <= 1'b1;
				else sub_clk <= 1'b1;
				cw(8);
				ext_clk <= 1'b0;
				sub_clk <= 1'b0;
				cw(8);
			end
			cw(10);
			stop();
			rd_cnt(c);
			chk("clk_count", 32'h1, {31'h0, c >= CK_LO[i] && c <= CK_HI[i]});
		end
		$display("t_clk done");
	endtask

	task t_cap();
		for (int i = 0; i < 4; i++) begin
			stop();
			set_cmp(10'h0);
			wr(OFF_CTRL1, {24'h0, 2'h1, 2'(i), 4'h0});
			wr(OFF_CTRL0, 32'h18);
			cw(10);
			n_a = 0;
			pin_in <= 1'b1;
			cw(12);
			pin_in <= 1'b0;
			cw(12);
			chk("capture_events", CAP_N[i], n_a);
		end
		$display("t_cap done");
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_clk = 1'b0;
		sub_clk = 1'b0;
		pin_in = 1'b0;
		fails = 0;
		compares = 0;
		cyc = 0;
		n_a = 0;
		n_p = 0;
		cw(2);
		presetn <= 1'b1;
		t_reset();
		t_pair();
		t_onpause();
		t_period();
		t_pin();
		t_pwm();
		t_single();
		t_clk();
		t_cap();
		end_of_test();
	end
endmodule

// ===== tmr_core.sv
/*
 * Standard 10-bit count-up timer with two comparators and its APB
 * register file. Assumes an APB3 master on pclk; the clock pin, the
 * sub clock and the timer pin arrive asynchronously and are synchronised.
 */
`timescale 1ns/1ns

// Functional notes
// - Pause holds count, release resumes it.
// - Clock select picks one of seven sources; two codes share the sub clock.
// - On rise clears count; fall keeps it.
// - On rise restores pin initial level.
// - Period bits match counter bits nine-seven.
// - Zero period lets counter overflow.
// - Two-bit field selects operating mode.
// - Timer/counter mode leaves pin undriven.
// - Compare match drives pin per function.
// - PWM function forces or generates waveform.
// - Capture edge selected by pin function.
// - Same level as initial gives no change.
// - Output control bit meaning depends mode.
// - Polarity bit inverts pin output.
// - Swap bit exchanges period and duty roles.
// - Clear select picks comparator A or P.
// - Clear select ignored outside compare modes.
// - Counter readable, upper bits read zero.
// - Compare A held; all fields reset zero.
// - Low bytes pass through byte buffers.
// - Each comparator match raises own event, except P when compare modes clear on A.
module tmr_core
	import tmr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Pins and clocks from outside.
	input  wire logic              external_clock_pin,
	input  wire logic              sub_clock_in,
	input  wire logic              timer_io_pin_in,
	output logic                   timer_io_pin_out,
	output logic                   timer_io_pin_oe,
	// Match events.
	output logic                   match_a_event,
	output logic                   match_p_event
);

	// ************************************************************
	// Registers
	// ************************************************************
	logic [7:0]       ctrl0_q;
	logic [7:0]       ctrl1_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cmpa_q;
	logic [7:0]       wbuf_q;
	logic [7:0]       rbuf_q;
	logic [31:0]      prdata_q;
	logic [PRE_W-1:0] pre_q;
	logic             on_d1_q;
	logic             out_q;
	logic             pin_q;
	logic             ev_a_q;
	logic             ev_p_q;
	logic [2:0]       sy1_q;
	logic [2:0]       sy2_q;
	logic [2:0]       sy3_q;
	logic [2:0]       lvl_q;

	// ************************************************************
	// Synchronisers
	// ************************************************************
	logic [2:0] raw;
	logic [2:0] lvl_d;
	logic [2:0] rise;
	logic [2:0] fall;

	assign raw = {timer_io_pin_in, sub_clock_in, external_clock_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			assign lvl_d[gi] = (sy2_q[gi] == sy3_q[gi]) ? sy3_q[gi] : lvl_q[gi];
			assign rise[gi] = lvl_d[gi] & ~lvl_q[gi];
			assign fall[gi] = ~lvl_d[gi] & lvl_q[gi];
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sy1_q[gi] <= 1'b0;
					sy2_q[gi] <= 1'b0;
					sy3_q[gi] <= 1'b0;
					lvl_q[gi] <= 1'b0;
				end else begin
					sy1_q[gi] <= raw[gi];
					sy2_q[gi] <= sy1_q[gi];
					sy3_q[gi] <= sy2_q[gi];
					lvl_q[gi] <= lvl_d[gi];
				end
			end
		end
	endgenerate

	// ************************************************************
	// Control fields
	// ************************************************************
	logic            pause;
	logic [2:0]      ck_sel;
	logic            on;
	logic [2:0]      per;
	tmr_mode_t       mode;
	logic [1:0]      pinf;
	logic            oc;
	logic            pol;
	logic            dpx;
	logic            clr_sel;

	assign pause   = ctrl0_q[C0_PAUSE];
	assign ck_sel  = ctrl0_q[C0_CK_HI:C0_CK_LO];
	assign on      = ctrl0_q[C0_ON];
	assign per     = ctrl0_q[C0_PR_HI:C0_PR_LO];
	assign mode    = tmr_mode_t'(ctrl1_q[C1_MD_HI:C1_MD_LO]);
	assign pinf    = ctrl1_q[C1_PF_HI:C1_PF_LO];
	assign oc      = ctrl1_q[C1_OC];
	assign pol     = ctrl1_q[C1_POL];
	assign dpx     = ctrl1_q[C1_DPX];
	assign clr_sel = ctrl1_q[C1_CLR];

	// ************************************************************
	// Clock source
	// ************************************************************
	logic tick;

	assign tick = (ck_sel == CK_SYS4) ? ((pre_q & DIV4_M) == DIV4_M) :
		(ck_sel == CK_SYS) ? 1'b1 :
		(ck_sel == CK_H16) ? ((pre_q & DIV16_M) == DIV16_M) :
		(ck_sel == CK_H64) ? (pre_q == DIV64_M) :
		(ck_sel == CK_SUB0 || ck_sel == CK_SUB1) ? rise[1] :
		(ck_sel == CK_EXTR) ? rise[0] : fall[0];

	// ************************************************************
	// Counter and comparators
	// ************************************************************
	logic           on_rise;
	logic           run;
	logic [CNT_W:0] nxt;
	logic [CNT_W:0] per_val;
	logic           hit_p;
	logic           hit_a;
	logic           cmp_like;
	logic           sp;
	logic           clr_on_a;
	logic           clr;
	logic           cap_evt;
	logic           sp_stop;
	logic [CNT_W-1:0] cnt_d;

	assign on_rise = on & ~on_d1_q;
	assign run     = on & ~pause & tick;
	assign nxt     = {1'b0, cnt_q} + 11'h001;
	assign per_val = (per == 3'h0) ? CNT_FULL : {1'b0, per, {PER_SH{1'b0}}};
	assign hit_p   = run & (nxt == per_val);
	assign hit_a   = run & (cmpa_q != CNT_RST) & (nxt == {1'b0, cmpa_q});
	assign cmp_like = (mode == MODE_CMP) || (mode == MODE_TC);
	assign sp       = (mode == MODE_PWM) && (pinf == PF_3);
	assign clr_on_a = cmp_like ? clr_sel : ((mode == MODE_PWM) & (sp | dpx));
	assign clr      = clr_on_a ? hit_a : hit_p;
	assign sp_stop  = sp & hit_a;

	assign cap_evt = (mode == MODE_CAP) & on & (
		(pinf == PF_0) ? rise[2] :
		(pinf == PF_1) ? fall[2] :
		(pinf == PF_2) ? (rise[2] | fall[2]) : 1'b0);

	assign cnt_d = on_rise ? CNT_RST :
		run ? (clr ? CNT_RST : nxt[CNT_W-1:0]) : cnt_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q   <= CNT_RST;
			pre_q   <= PRE_RST;
			on_d1_q <= 1'b0;
			ev_a_q  <= 1'b0;
			ev_p_q  <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			pre_q   <= pre_q + 6'h01;
			on_d1_q <= on;
			ev_a_q  <= hit_a | cap_evt;
			ev_p_q  <= hit_p & ~(cmp_like & clr_sel);
		end
	end

	assign match_a_event = ev_a_q;
	assign match_p_event = ev_p_q;

	// ************************************************************
	// Output pin
	// ************************************************************
	logic pwm_act;
	logic out_d;

	assign pwm_act = dpx ? ({1'b0, cnt_q} < per_val) : (cnt_q < cmpa_q);

	always_comb begin
		out_d = out_q;
		if (on_rise && (mode == MODE_CMP || mode == MODE_PWM)) begin
			out_d = oc;
		end else begin
			case (mode)
				MODE_CMP: begin
					if (hit_a) begin
						case (pinf)
							PF_1: out_d = 1'b0;
							PF_2: out_d = 1'b1;
							PF_3: out_d = ~out_q;
							default: out_d = out_q;
						endcase
					end
				end
				MODE_PWM: begin
					case (pinf)
						PF_0: out_d = ~oc;
						PF_1: out_d = oc;
						PF_2: out_d = on ? (pwm_act ? oc : ~oc) : out_q;
						default: out_d = sp_stop ? ~oc : out_q;
					endcase
				end
				default: out_d = out_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 1'b0;
			pin_q <= 1'b0;
		end else begin
			out_q <= out_d;
			pin_q <= out_d ^ pol;
		end
	end

	assign timer_io_pin_out = pin_q;
	assign timer_io_pin_oe  = (mode == MODE_CMP) || (mode == MODE_PWM);

	// ************************************************************
	// APB register file
	// ************************************************************
	function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		at = (a == ADDR_W'(off));
	endfunction

	logic        setup;
	logic        acc;
	logic        wr;
	logic        rd_set;
	logic        h_c0;
	logic        h_c1;
	logic        h_dl;
	logic        h_dh;
	logic        h_al;
	logic        h_ah;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [7:0]  ctrl0_d;

	assign setup  = psel & ~penable;
	assign acc    = psel & penable;
	assign wr     = acc & pwrite;
	assign rd_set = setup & ~pwrite;
	assign h_c0   = at(paddr, OFF_CTRL0);
	assign h_c1   = at(paddr, OFF_CTRL1);
	assign h_dl   = at(paddr, OFF_CNT_LO);
	assign h_dh   = at(paddr, OFF_CNT_HI);
	assign h_al   = at(paddr, OFF_CMP_LO);
	assign h_ah   = at(paddr, OFF_CMP_HI);
	assign mapped = h_c0 | h_c1 | h_dl | h_dh | h_al | h_ah;

	assign rd_mux = h_c0 ? {24'h000000, ctrl0_q} :
		h_c1 ? {24'h000000, ctrl1_q} :
		(h_dl | h_al) ? {24'h000000, rbuf_q} :
		h_dh ? {30'h0, cnt_q[CNT_W-1:BYTE_W]} :
		h_ah ? {30'h0, cmpa_q[CNT_W-1:BYTE_W]} : 32'h00000000;

	// Hardware ends a single pulse by dropping the on bit; a write wins.
	assign ctrl0_d = (wr & h_c0) ? pwdata[7:0] :
		sp_stop ? (ctrl0_q & ~(8'h01 << C0_ON)) : ctrl0_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_q  <= CTRL_RST;
			ctrl1_q  <= CTRL_RST;
			cmpa_q   <= CNT_RST;
			wbuf_q   <= CTRL_RST;
			rbuf_q   <= CTRL_RST;
			prdata_q <= 32'h00000000;
		end else begin
			ctrl0_q <= ctrl0_d;
			if (wr & h_c1) begin
				ctrl1_q <= pwdata[7:0];
			end
			if (wr & h_al) begin
				wbuf_q <= pwdata[7:0];
			end
			if (cap_evt) begin
				cmpa_q <= cnt_q;
			end else if (wr & h_ah) begin
				cmpa_q <= {pwdata[1:0], wbuf_q};
			end
			if (rd_set & h_dh) begin
				rbuf_q <= cnt_q[7:0];
			end else if (rd_set & h_ah) begin
				rbuf_q <= cmpa_q[7:0];
			end
			if (rd_set) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// ************************************************************
	// Assertions
	// ************************************************************
	a_pause_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(on && pause && !on_rise) |=> (cnt_q == $past(cnt_q)))
		else $error("Counter moved while paused.");

	a_on_rise_clear: assert property (@(posedge pclk) disable iff (!presetn)
		on_rise |=> (cnt_q == CNT_RST))
		else $error("Counter not cleared on enable.");

	a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!on && !on_d1_q) |=> $stable(cnt_q))
		else $error("Counter moved while off.");

	a_ovf_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(run && per == 3'h0 && !clr_on_a && cnt_q == 10'h3FF && !on_rise)
		|=> (cnt_q == CNT_RST) && match_p_event == !(cmp_like && clr_sel))
		else $error("Overflow wrap or period event wrong.");

	a_period_p: assert property (@(posedge pclk) disable iff (!presetn)
		(run && !clr_on_a && !on_rise && per != 3'h0 && cnt_q == {per, 7'h7F})
		|=> (cnt_q == CNT_RST))
		else $error("Period clear missed.");

	a_hi_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite && (h_dh || h_ah)) |-> (prdata[31:2] == 30'h00000000))
		else $error("High byte upper bits not zero.");

	a_buf_commit: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && h_ah && !cap_evt) |=> (cmpa_q[7:0] == $past(wbuf_q)))
		else $error("Low byte not committed from buffer.");

	a_tc_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == MODE_TC || mode == MODE_CAP) |-> !timer_io_pin_oe)
		else $error("Pin driven in non-output mode.");

	a_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == MODE_CMP && hit_a && pinf == PF_3 && !on_rise)
		|=> (out_q != $past(out_q)))
		else $error("Toggle on match missing.");

	a_force_act: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == MODE_PWM && pinf == PF_1) |=> (out_q == $past(oc)))
		else $error("Forced active level wrong.");

	a_polarity: assert property (@(posedge pclk) disable iff (!presetn)
		##1 ((timer_io_pin_out ^ out_q) == $past(pol)))
		else $error("Pin polarity wrong.");

	a_init_level: assert property (@(posedge pclk) disable iff (!presetn)
		(on_rise && (mode == MODE_CMP || mode == MODE_PWM)) |=> (out_q == $past(oc)))
		else $error("Initial level not restored.");

endmodule

// ===== tmr_pkg.sv
/*
 * Shared constants for the standard timer: register offsets, field
 * positions, reset values and the encodings of modes and pin functions.
 * Assumes a 32-bit APB slave with byte addresses.
 */
package tmr_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int CNT_W  = 10;
	localparam int BYTE_W = 8;
	localparam int PRE_W  = 6;
	localparam int PER_SH = 7;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFF_CTRL0  = 8'h00;
	localparam logic [7:0] OFF_CTRL1  = 8'h04;
	localparam logic [7:0] OFF_CNT_LO = 8'h08;
	localparam logic [7:0] OFF_CNT_HI = 8'h0C;
	localparam logic [7:0] OFF_CMP_LO = 8'h10;
	localparam logic [7:0] OFF_CMP_HI = 8'h14;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int C0_PAUSE = 7;
	localparam int C0_CK_HI = 6;
	localparam int C0_CK_LO = 4;
	localparam int C0_ON    = 3;
	localparam int C0_PR_HI = 2;
	localparam int C0_PR_LO = 0;
	localparam int C1_MD_HI = 7;
	localparam int C1_MD_LO = 6;
	localparam int C1_PF_HI = 5;
	localparam int C1_PF_LO = 4;
	localparam int C1_OC    = 3;
	localparam int C1_POL   = 2;
	localparam int C1_DPX   = 1;
	localparam int C1_CLR   = 0;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0]       CTRL_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST  = 10'h000;
	localparam logic [PRE_W-1:0] PRE_RST  = 6'h00;

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_CMP = 2'h0,
		MODE_CAP = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TC  = 2'h3
	} tmr_mode_t;

	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS  = 3'h1;
	localparam logic [2:0] CK_H16  = 3'h2;
	localparam logic [2:0] CK_H64  = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;
	localparam logic [2:0] CK_EXTR = 3'h6;

	localparam logic [PRE_W-1:0] DIV4_M  = 6'h03;
	localparam logic [PRE_W-1:0] DIV16_M = 6'h0F;
	localparam logic [PRE_W-1:0] DIV64_M = 6'h3F;

	localparam logic [1:0] PF_0 = 2'h0;
	localparam logic [1:0] PF_1 = 2'h1;
	localparam logic [1:0] PF_2 = 2'h2;
	localparam logic [1:0] PF_3 = 2'h3;

	localparam logic [CNT_W:0] CNT_FULL = 11'h400;

endpackage
